// ---- verification/bii_core_chk.sv ----
// Port-level concurrent checks for the bit-invert unit, bound into bii_core
`timescale 1ns/1ps

module bii_core_chk (
  // Clock and reset
  input wire logic                 clock_in,
  input wire logic                 nrst_in,
  // Watched ports
  input wire logic                 instr_valid_in,
  input wire logic [15:0]          instr_in,
  input wire bii_pkg::bii_ctx_t    ctx_in,
  input wire logic [7:0]           dm_rdata_in,
  input wire bii_pkg::bii_dm_req_t dm_req_out,
  input wire logic                 bit_invert_op_out,
  input wire logic [1:0]           mode_out,
  input wire logic [1:0]           phase_out,
  input wire logic                 done_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  // phase_out lags the sequencer, so 3 here marks the Q1 clock
  sequence s_take;
    phase_out == 2'd3 && instr_valid_in && instr_in[15:12] == 4'h7;
  endsequence

  property p_seq;
    s_take |=> dm_req_out.rd && bit_invert_op_out ##1 !dm_req_out.rd ##1 dm_req_out.wr
      ##1 done_out && !dm_req_out.wr;
  endproperty
  a_seq: assert property (p_seq) else $error("bit invert cycle out of step");

  property p_wdata;
    logic [2:0] b;
    (s_take ##0 (1'b1, b = instr_in[11:9])) |->
      ##3 dm_req_out.wdata == ($past(dm_rdata_in) ^ (8'h01 << b));
  endproperty
  a_wdata: assert property (p_wdata) else $error("wrong bit inverted");

  property p_ignore;
    phase_out == 2'd3 && !(instr_valid_in && instr_in[15:12] == 4'h7) |=>
      !dm_req_out.rd && !bit_invert_op_out;
  endproperty
  a_ignore: assert property (p_ignore) else $error("foreign opcode executed");

  property p_access;
    logic [11:0] x;
    (s_take ##0 (!instr_in[8] && (!ctx_in.ext_set_en || instr_in[7:0] > 8'h5f),
      x = {(instr_in[7:0] > 8'h5f) ? 4'hf : 4'h0, instr_in[7:0]})) |=>
      dm_req_out.addr == x && mode_out == 2'd0;
  endproperty
  a_access: assert property (p_access) else $error("access bank address wrong");

  property p_bank;
    logic [11:0] x;
    (s_take ##0 (instr_in[8], x = {ctx_in.bank_select_reg, instr_in[7:0]})) |=>
      dm_req_out.addr == x && mode_out == 2'd1;
  endproperty
  a_bank: assert property (p_bank) else $error("banked address wrong");

  property p_index;
    logic [11:0] x;
    (s_take ##0 (!instr_in[8] && ctx_in.ext_set_en && instr_in[7:0] <= 8'h5f,
      x = ctx_in.index_base + 12'(instr_in[7:0]))) |=> dm_req_out.addr == x && mode_out == 2'd2;
  endproperty
  a_index: assert property (p_index) else $error("indexed address wrong");

  property p_wr_cause;
    dm_req_out.wr |-> $past(dm_req_out.rd, 2) && $stable(dm_req_out.addr);
  endproperty
  a_wr_cause: assert property (p_wr_cause) else $error("write without read");

  c_bank: cover property (s_take ##0 instr_in[8]);
  c_index: cover property (s_take ##0
    (ctx_in.ext_set_en && !instr_in[8] && instr_in[7:0] <= 8'h5f));
  c_done: cover property (done_out);
endmodule : bii_core_chk

bind bii_core bii_core_chk u_chk (.clock_in(clock_in), .nrst_in(nrst_in),
  .instr_valid_in(instr_valid_in), .instr_in(instr_in), .ctx_in(ctx_in),
  .dm_rdata_in(dm_rdata_in), .dm_req_out(dm_req_out), .bit_invert_op_out(bit_invert_op_out),
  .mode_out(mode_out), .phase_out(phase_out), .done_out(done_out));

// ---- verification/bii_dm_model.sv ----
// Behavioural data memory answering one clock after a read strobe
`timescale 1ns/1ps

module bii_dm_model (
  // Clock
  input  wire logic                 clock_in,
  // Request and answer
  input  wire bii_pkg::bii_dm_req_t req_in,
  output logic [7:0]                rdata_out
);
  logic [7:0] mem [4096];

  initial begin
    rdata_out = 8'h00;
    for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'(i >> 4);
  end

  // Outside the answer cycle the data churns, so a mistimed sample reads garbage
  always @(posedge clock_in) begin
    rdata_out <= req_in.rd ? mem[req_in.addr] : ~rdata_out;
    if (req_in.wr) mem[req_in.addr] <= req_in.wdata;
  end
endmodule : bii_dm_model

// ---- verification/tb.sv ----
// Self-checking bench for the bit-invert unit against a data memory model
`timescale 1ns/1ps

module tb;
  logic                 clock_in, nrst_in, instr_valid_in, bit_invert_op_out, done_out;
  logic [15:0]          instr_in;
  logic [7:0]           dm_rdata_in;
  logic [1:0]           mode_out, phase_out;
  bii_pkg::bii_ctx_t    ctx_in;
  bii_pkg::bii_dm_req_t dm_req_out;
  int                   n_mismatch, checked, seed;
  logic                 wr_prev;
  logic [7:0]           ref_mem [4096];
  logic [21:0]          exp_q [$];
  logic [16:0]          cn [5] = '{17'h17e5f, 17'h17060, 17'h17100, 17'h07a5f, 17'h16e12};

  bii_core u_bii_core (.clock_in(clock_in), .nrst_in(nrst_in), .instr_valid_in(instr_valid_in),
    .instr_in(instr_in), .ctx_in(ctx_in), .dm_rdata_in(dm_rdata_in), .dm_req_out(dm_req_out),
    .bit_invert_op_out(bit_invert_op_out), .mode_out(mode_out), .phase_out(phase_out),
    .done_out(done_out));
  bii_dm_model u_bii_dm_model (.clock_in(clock_in), .req_in(dm_req_out), .rdata_out(dm_rdata_in));

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  task automatic test_done;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp

  function automatic logic [13:0] exp_am(logic [15:0] i, bii_pkg::bii_ctx_t c);
    if (i[8]) return {2'd1, c.bank_select_reg, i[7:0]};
    if (c.ext_set_en && i[7:0] <= 8'h5f) return {2'd2, c.index_base + 12'(i[7:0])};
    return {2'd0, (i[7:0] > 8'h5f) ? 4'hf : 4'h0, i[7:0]};
  endfunction : exp_am

  task automatic issue(input logic v, input logic [15:0] i, input bii_pkg::bii_ctx_t c);
    logic [13:0] e;
    e = exp_am(i, c);
    instr_valid_in = v;
    instr_in = i;
    ctx_in = c;
    if (v && i[15:12] == 4'h7) begin
      ref_mem[e[11:0]] ^= 8'h01 << i[11:9];
      exp_q.push_back({e[11:0], ref_mem[e[11:0]], e[13:12]});
    end
  endtask : issue

  // Instructions are handed over right after the edge that ends Q1
  task automatic next_q1;
    for (int k = 0; k < 8; k++) begin
      @(posedge clock_in);
      #1;
      if (phase_out === 2'd0) return;
    end
    n_mismatch++;
    $display("unexpected at %0t: phase stuck", $time);
    test_done;
  endtask : next_q1

  // Sampled mid-clock, where every registered output has settled
  always @(negedge clock_in) begin
    if (!nrst_in) begin
      wr_prev = 1'b0;
    end else begin
      cmp(12'(done_out), 12'(wr_prev));
      wr_prev = dm_req_out.wr;
      if (dm_req_out.wr === 1'b1) begin
        if (exp_q.size() == 0) cmp(12'h001, 12'h000);
        else begin
          cmp(dm_req_out.addr, exp_q[0][21:10]);
          cmp(12'(dm_req_out.wdata), 12'(exp_q[0][9:2]));
          cmp(12'(mode_out), 12'(exp_q[0][1:0]));
          void'(exp_q.pop_front());
        end
      end
    end
  end

  initial begin
    seed = 32'hd685;
    n_mismatch = 0;
    checked = 0;
    wr_prev = 1'b0;
    nrst_in = 1'b0;
    for (int i = 0; i < 4096; i++) ref_mem[i] = 8'(i) ^ 8'(i >> 4);
    issue(1'b1, 16'h7e5f, {4'h3, 12'hffa, 1'b1});
    repeat (6) @(posedge clock_in);
    #1 nrst_in = 1'b1;
    foreach (cn[j]) begin
      next_q1;
      issue(1'b1, cn[j][15:0], {4'h3, 12'h100, cn[j][16]});
    end
    next_q1;
    issue(1'b0, 16'h7234, 17'h00000);
    for (int k = 0; k < 300; k++) begin
      next_q1;
      issue($random(seed) % 8 != 0, {($random(seed) % 4 == 0) ? 4'($random(seed)) : 4'h7,
        12'($random(seed))}, bii_pkg::bii_ctx_t'(17'($random(seed))));
    end
    next_q1;
    issue(1'b0, 16'h0000, 17'h00000);
    repeat (8) @(posedge clock_in);
    cmp(12'(exp_q.size()), 12'h000);
    test_done;
  end
endmodule : tb

// ---- verilog/bii_core.sv ----
// Decode and execution of the single-word bit-invert instruction
`timescale 1ns/1ps

// Operation
// - Decode 0111 bbba, invert only bit b
// - Access flag clear: address the access bank
// - Access flag set: bank select chooses bank
// - Extended set, a=0, f<=5Fh: indexed offset
module bii_core (
  // Clock and reset
  input  wire logic                      clock_in,
  input  wire logic                      nrst_in,
  // Instruction fetch path, sampled in Q1
  input  wire logic                      instr_valid_in,
  input  wire logic [15:0]               instr_in,
  // Core context
  input  wire bii_pkg::bii_ctx_t         ctx_in,
  // Data memory port
  input  wire logic [7:0]                dm_rdata_in,
  output bii_pkg::bii_dm_req_t           dm_req_out,
  // Status
  output logic                           bit_invert_op_out,
  output logic [1:0]                     mode_out,
  output logic [1:0]                     phase_out,
  output logic                           done_out
);

  bii_pkg::bii_phase_t phase;
  bii_pkg::bii_phase_t phase_q;

  // Decode wires
  logic [3:0]         opc_field;
  logic               opc_hit;
  logic [2:0]         bit_idx;
  logic               access_flag;
  logic [7:0]         faddr;
  logic               low_half;
  logic [2:0]         sel_code;
  logic [11:0]        addr_d;
  bii_pkg::bii_mode_t mode_d;

  // Phase strobes
  logic               in_q1;
  logic               in_q3;
  logic               in_q4;

  // Per-bit inversion
  logic [7:0]         flip_mask;
  logic [7:0]         wdata_d;

  // Execution state
  logic        active_q;
  logic [2:0]  bit_idx_q;
  logic [11:0] addr_q;
  logic [7:0]  wdata_q;
  logic        rd_q;
  logic        wr_q;
  logic        done_q;
  bii_pkg::bii_mode_t mode_q;

  bii_qphase u_qphase (
    .clock_in  (clock_in),
    .nrst_in   (nrst_in),
    .phase_out (phase)
  );

  // Field extraction
  assign opc_field   = instr_in[bii_pkg::OPC_MSB:bii_pkg::OPC_LSB];
  assign opc_hit     = instr_valid_in && (opc_field == bii_pkg::OPC_BIT_INVERT);
  assign bit_idx     = instr_in[bii_pkg::BIT_IDX_MSB:bii_pkg::BIT_IDX_LSB];
  assign access_flag = instr_in[bii_pkg::ACCESS_BIT];
  assign faddr       = instr_in[bii_pkg::FADDR_MSB:bii_pkg::FADDR_LSB];
  assign low_half    = (faddr <= bii_pkg::ACCESS_LOW_MAX);
  assign sel_code    = {access_flag, ctx_in.ext_set_en, low_half};

  // Address resolution, keyed by {access flag, extended set, low half}
  // The access flag wins; the extended set only reroutes low-half access hits
  always_comb begin
    case (sel_code)
      3'b100, 3'b101, 3'b110, 3'b111: begin
        mode_d = bii_pkg::BII_MODE_BANKED;
        addr_d = {ctx_in.bank_select_reg, faddr};
      end
      3'b011: begin
        // The offset is unsigned; a base near the top of memory wraps around
        mode_d = bii_pkg::BII_MODE_INDEXED;
        addr_d = 12'(ctx_in.index_base + {4'h0, faddr});
      end
      3'b001: begin
        mode_d = bii_pkg::BII_MODE_ACCESS;
        addr_d = {bii_pkg::ACCESS_LO_BANK, faddr};
      end
      default: begin
        // Upper part of the access bank always maps onto the special registers
        mode_d = bii_pkg::BII_MODE_ACCESS;
        addr_d = {bii_pkg::ACCESS_HI_BANK, faddr};
      end
    endcase
  end

  // One strobe per working phase, so every stage but the busy flag keys off a plain flag
  // Q2 needs none: the read strobe is launched from the Q1 decode itself
  always_comb begin
    in_q1 = 1'b0;
    in_q3 = 1'b0;
    in_q4 = 1'b0;
    case (phase)
      bii_pkg::BII_Q1: begin
        in_q1 = 1'b1;
      end
      bii_pkg::BII_Q3: begin
        in_q3 = 1'b1;
      end
      bii_pkg::BII_Q4: begin
        in_q4 = 1'b1;
      end
      default: begin
        in_q1 = 1'b0;
      end
    endcase
  end

  // Phase tracking for the status output
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase_q <= bii_pkg::BII_Q1;
    end else begin
      phase_q <= phase;
    end
  end

  // Busy flag: raised by a decoded bit invert in Q1, dropped after the Q4 write
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      active_q <= 1'b0;
    end else begin
      case (phase)
        bii_pkg::BII_Q1: begin
          active_q <= opc_hit;
        end
        bii_pkg::BII_Q4: begin
          active_q <= 1'b0;
        end
        default: begin
          active_q <= active_q;
        end
      endcase
    end
  end

  // Operand capture at the end of Q1; held until the next bit invert, so the
  // address cannot move between the read and the write of one instruction
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bit_idx_q <= bii_pkg::BIT_IDX_RST;
      addr_q    <= bii_pkg::DADDR_RST;
      mode_q    <= bii_pkg::BII_MODE_ACCESS;
    end else if (in_q1 && opc_hit) begin
      bit_idx_q <= bit_idx;
      addr_q    <= addr_d;
      mode_q    <= mode_d;
    end
  end

  // Read strobe is high for the whole of Q2; the memory answers during Q3
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_q <= 1'b0;
    end else begin
      rd_q <= in_q1 && opc_hit;
    end
  end

  // One comparator per data bit: only the indexed bit flips, the rest pass through
  for (genvar gi = 0; gi < bii_pkg::DATA_W; gi++) begin : g_flip
    assign flip_mask[gi] = (bit_idx_q == 3'(gi));
    assign wdata_d[gi]   = dm_rdata_in[gi] ^ flip_mask[gi];
  end

  // Process in Q3: the read data is only valid in that clock
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wdata_q <= bii_pkg::DATA_RST;
    end else if (in_q3 && active_q) begin
      wdata_q <= wdata_d;
    end
  end

  // Write strobe is high for the whole of Q4
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_q <= 1'b0;
    end else begin
      wr_q <= in_q3 && active_q;
    end
  end

  // Completion pulse in the Q1 that follows the write
  // Lets the core retire the instruction without tracking phases itself
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      done_q <= 1'b0;
    end else begin
      done_q <= in_q4 && active_q;
    end
  end

  // No status flag is touched: the unit has no path to the status register
  // The request is built in one process so the carrier has a single driver
  always_comb begin
    dm_req_out.addr  = addr_q;
    dm_req_out.wdata = wdata_q;
    dm_req_out.rd    = rd_q;
    dm_req_out.wr    = wr_q;
  end

  // Status outputs
  assign bit_invert_op_out  = active_q;
  assign mode_out           = mode_q;
  assign phase_out          = phase_q;
  assign done_out           = done_q;

endmodule : bii_core

// ---- verilog/bii_pkg.sv ----
// Package for the bit-invert instruction unit: opcode fields, address map, phases, carriers
package bii_pkg;

  // Instruction word layout: 0111 bbba ffff ffff
  localparam int          INSTR_W        = 16;
  localparam logic [3:0]  OPC_BIT_INVERT = 4'h7;
  localparam int          OPC_MSB        = 15;
  localparam int          OPC_LSB        = 12;
  localparam int          BIT_IDX_MSB    = 11;
  localparam int          BIT_IDX_LSB    = 9;
  localparam int          ACCESS_BIT     = 8;
  localparam int          FADDR_MSB      = 7;
  localparam int          FADDR_LSB      = 0;

  // Data memory address map
  localparam int          DADDR_W        = 12;
  localparam int          BANK_W         = 4;
  localparam int          DATA_W         = 8;
  localparam logic [7:0]  ACCESS_LOW_MAX = 8'h5f;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hf;
  localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;

  // Reset values
  localparam logic [11:0] DADDR_RST      = 12'h000;
  localparam logic [7:0]  DATA_RST       = 8'h00;
  localparam logic [2:0]  BIT_IDX_RST    = 3'h0;

  // Timing: one instruction cycle is four clocks
  localparam real         CLK_PERIOD_NS  = 10.0;
  localparam int          Q_PER_CYCLE    = 4;

  // Phase of the four-phase instruction cycle
  typedef enum logic [1:0] {
    BII_Q1 = 2'b00,
    BII_Q2 = 2'b01,
    BII_Q3 = 2'b10,
    BII_Q4 = 2'b11
  } bii_phase_t;

  // Addressing mode resolved at decode
  typedef enum logic [1:0] {
    BII_MODE_ACCESS  = 2'b00,
    BII_MODE_BANKED  = 2'b01,
    BII_MODE_INDEXED = 2'b10
  } bii_mode_t;

  // Request toward the data memory / register file
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
  } bii_dm_req_t;

  // Core context needed to resolve the address
  typedef struct packed {
    logic [3:0]  bank_select_reg;
    logic [11:0] index_base;
    logic        ext_set_en;
  } bii_ctx_t;

endpackage : bii_pkg

// ---- verilog/bii_qphase.sv ----
// Four-phase instruction cycle sequencer
`timescale 1ns/1ps

module bii_qphase (
  // Clock and reset
  input  wire logic               clock_in,
  input  wire logic               nrst_in,
  // Phase
  output bii_pkg::bii_phase_t     phase_out
);

  bii_pkg::bii_phase_t phase_q;

  // Free-running: Q1 follows reset release, then Q2, Q3, Q4, Q1 ...
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase_q <= bii_pkg::BII_Q1;
    end else begin
      case (phase_q)
        bii_pkg::BII_Q1: phase_q <= bii_pkg::BII_Q2;
        bii_pkg::BII_Q2: phase_q <= bii_pkg::BII_Q3;
        bii_pkg::BII_Q3: phase_q <= bii_pkg::BII_Q4;
        bii_pkg::BII_Q4: phase_q <= bii_pkg::BII_Q1;
        default:         phase_q <= bii_pkg::BII_Q1;
      endcase
    end
  end

  assign phase_out = phase_q;

endmodule : bii_qphase
